// file: cfa_pkg.sv
// Constants shared by the frame, error and arbitration logic.
// Assumes one sample per nominal bit, flagged by a bit tick.
package cfa_pkg;

  // ==========================================================
  // Bus levels
  localparam logic DOMINANT  = 1'h0;
  localparam logic RECESSIVE = 1'h1;

  // ==========================================================
  // Bit counts, kept as last index of each field or full length of each run
  localparam int        CNT_W      = 3;
  localparam logic [2:0] INTER_LAST = 3'h2;   // 3 bits
  localparam logic [2:0] OVLW_LAST  = 3'h1;   // Overload window, bits 1-2
  localparam logic [2:0] SUSP_LAST  = 3'h7;   // 8 bits
  localparam logic [2:0] FLAG_LAST  = 3'h5;   // 6 bits
  localparam logic [2:0] FLAG_RUN   = 3'h6;   // 6 equal levels
  localparam logic [2:0] DELIM_LAST = 3'h7;   // 8 bits
  localparam logic [2:0] STUFF_RUN  = 3'h5;   // 5 equal levels
  localparam logic [2:0] CNT_ONE    = 3'h1;
  localparam logic [2:0] CNT_ZERO   = 3'h0;

  // ==========================================================
  // Protocol states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_FRAME     = 3'h1,
    ST_ERR_FLAG  = 3'h3,
    ST_ERR_DELIM = 3'h2,
    ST_INTER     = 3'h6,
    ST_SUSPEND   = 3'h7,
    ST_OVL_FLAG  = 3'h5,
    ST_OVL_DELIM = 3'h4
  } cfa_state_e;

  // Increment of a bit counter
  function automatic logic [2:0] cfa_inc(input logic [2:0] v);
    return v + CNT_ONE;
  endfunction

endpackage

// file: cfa_stuff.sv
// Run-length tracker of sampled bus bits for stuffing.
// Assumes bits arrive once per bit tick on the same clock.
`timescale 1ns/100ps
`default_nettype none
module cfa_stuff
  import cfa_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic tick,
  input  wire logic clr,
  input  wire logic en,
  input  wire logic busBit,
  output var  logic stuffNow,
  output var  logic stuffNext,
  output var  logic stuffErr
);

  logic             last;
  logic [CNT_W-1:0] run;
  logic [CNT_W-1:0] next_run;

  // ==========================================================
  // Run of equal levels
  always_comb begin
    next_run = (busBit == last) ? cfa_inc(run) : CNT_ONE;
  end

  assign stuffNext = en && !stuffNow && (next_run == STUFF_RUN);
  assign stuffErr  = tick && en && stuffNow && (busBit == last);

  always_ff @(posedge ref_clk) begin
    if (srst || clr) begin
      last     <= RECESSIVE;
      run      <= CNT_ZERO;
      stuffNow <= 1'h0;
    end else if (tick && en) begin
      last <= busBit;
      if (stuffNow) begin
        run      <= CNT_ONE;
        stuffNow <= 1'h0;
      end else begin
        run      <= next_run;
        stuffNow <= (next_run == STUFF_RUN);
      end
    end else if (tick) begin
      stuffNow <= 1'h0;
    end
  end

endmodule // cfa_stuff
`default_nettype wire

// file: cfa_skid_buf.sv
// Two-entry buffer for received bits, output from registers.
// Assumes the drain side may stall at any cycle.
`timescale 1ns/100ps
`default_nettype none
module cfa_skid_buf (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic inValid,
  input  wire logic inData,
  output var  logic inReady,
  output var  logic outValid,
  output var  logic outData,
  input  wire logic outReady
);

  logic skidValid;
  logic skidData;

  assign inReady = !skidValid;

  // ==========================================================
  // Output stage and skid entry
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      outValid  <= 1'h0;
      outData   <= 1'h0;
      skidValid <= 1'h0;
      skidData  <= 1'h0;
    end else if (outReady || !outValid) begin
      if (skidValid) begin
        outData   <= skidData;
        outValid  <= 1'h1;
        skidValid <= 1'h0;
      end else begin
        outData  <= inData;
        outValid <= inValid;
      end
    end else if (inValid && !skidValid) begin
      skidData  <= inData;
      skidValid <= 1'h1;
    end
  end

endmodule // cfa_skid_buf
`default_nettype wire

// file: cfa_core.sv
// Bit-level CAN protocol: interframe, error, overload, arbitration.
// Assumes a bit tick at each sample point, at least 3 clocks apart,
// and a message handler that walks the frame fields.
`timescale 1ns/100ps
`default_nettype none
module cfa_core
  import cfa_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic bitTick,
  input  wire logic canRx,
  output var  logic canTx,
  input  wire logic txPending,
  input  wire logic txBit,
  input  wire logic txArb,
  output var  logic txTake,
  input  wire logic stuffRegion,
  input  wire logic errDetect,
  input  wire logic crcErr,
  input  wire logic ackDelim,
  input  wire logic eofLast,
  input  wire logic errPassive,
  output var  logic rxValid,
  output var  logic rxBit,
  input  wire logic rxReady,
  output var  logic rxOverrun,
  output var  logic txActive,
  output var  logic arbLost,
  output var  logic sofSeen,
  output var  logic busIdle
);

  cfa_state_e       state;
  logic             rxMeta;
  logic             rxS;
  logic [CNT_W-1:0] bitCnt;
  logic [CNT_W-1:0] eqCnt;
  logic [CNT_W-1:0] next_eq;
  logic             lastLvl;
  logic             flagPassive;
  logic             delimRun;
  logic             wasTx;
  logic             crcPend;
  logic             stuffNow;
  logic             stuffNext;
  logic             stuffErr;
  logic             stuffOn;
  logic             sofRx;
  logic             pushValid;
  logic             pushReady;
  logic             dom;

  // ==========================================================
  // Bus input synchroniser
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rxMeta <= RECESSIVE;
      rxS    <= RECESSIVE;
    end else begin
      rxMeta <= canRx;
      rxS    <= rxMeta;
    end
  end

  assign dom = (rxS == DOMINANT);

  // ==========================================================
  // Stuffing shared by sender and receiver
  assign sofRx = dom && ((state == ST_IDLE) || (state == ST_SUSPEND) ||
                 ((state == ST_INTER) && (bitCnt == INTER_LAST)));
  assign stuffOn = ((state == ST_FRAME) && stuffRegion) || sofRx;

  cfa_stuff u_stuff (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .tick      (bitTick),
    .clr       (!stuffOn && (state != ST_FRAME)),
    .en        (stuffOn),
    .busBit    (rxS),
    .stuffNow  (stuffNow),
    .stuffNext (stuffNext),
    .stuffErr  (stuffErr)
  );

  // ==========================================================
  // Received bits to the message handler
  assign pushValid = bitTick && !stuffNow &&
                     ((state == ST_FRAME) || sofRx);

  cfa_skid_buf u_rxbuf (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .inValid  (pushValid),
    .inData   (rxS),
    .inReady  (pushReady),
    .outValid (rxValid),
    .outData  (rxBit),
    .outReady (rxReady)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rxOverrun <= 1'h0;
    end else if (pushValid && !pushReady) begin
      rxOverrun <= 1'h1;
    end
  end

  // ==========================================================
  // Deferred CRC error, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      crcPend <= 1'h0;
    end else if (crcErr && (state == ST_FRAME)) begin
      crcPend <= 1'h1;
    end else if (state != ST_FRAME) begin
      crcPend <= 1'h0;
    end
  end

  // ==========================================================
  // Passive flag run of equal levels
  always_comb begin
    next_eq = ((eqCnt != CNT_ZERO) && (rxS == lastLvl)) ?
              cfa_inc(eqCnt) : CNT_ONE;
  end

  // ==========================================================
  // Protocol sequencer, one step per sampled bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state       <= ST_INTER;
      canTx       <= RECESSIVE;
      bitCnt      <= CNT_ZERO;
      eqCnt       <= CNT_ZERO;
      lastLvl     <= RECESSIVE;
      flagPassive <= 1'h0;
      delimRun    <= 1'h0;
      wasTx       <= 1'h0;
      txActive    <= 1'h0;
      txTake      <= 1'h0;
      arbLost     <= 1'h0;
      sofSeen     <= 1'h0;
      busIdle     <= 1'h0;
    end else begin
      txTake  <= 1'h0;
      arbLost <= 1'h0;
      sofSeen <= 1'h0;
      busIdle <= (state == ST_IDLE);
      if (bitTick) begin
        case (state)
          ST_IDLE: begin
            if (dom) begin
              state   <= ST_FRAME;
              sofSeen <= 1'h1;
            end else if (txPending) begin
              state    <= ST_FRAME;
              canTx    <= DOMINANT;
              txActive <= 1'h1;
              sofSeen  <= 1'h1;
            end
          end
          ST_FRAME: begin
            if (errDetect || (stuffErr && !txActive) ||
                (ackDelim && crcPend)) begin
              state       <= ST_ERR_FLAG;
              bitCnt      <= CNT_ZERO;
              eqCnt       <= CNT_ZERO;
              flagPassive <= errPassive;
              canTx       <= errPassive ? RECESSIVE : DOMINANT;
              wasTx       <= txActive;
              txActive    <= 1'h0;
            end else if (eofLast) begin
              wasTx    <= txActive;
              txActive <= 1'h0;
              bitCnt   <= CNT_ZERO;
              if (dom) begin
                state <= ST_OVL_FLAG;
                canTx <= DOMINANT;
              end else begin
                state <= ST_INTER;
                canTx <= RECESSIVE;
              end
            end else if (txActive && txArb && !stuffNow &&
                         (canTx == RECESSIVE) && dom) begin
              txActive <= 1'h0;
              canTx    <= RECESSIVE;
              arbLost  <= 1'h1;
            end else if (txActive && stuffNext) begin
              canTx <= ~rxS;
            end else if (txActive) begin
              canTx  <= txBit;
              txTake <= 1'h1;
            end else begin
              canTx <= RECESSIVE;
            end
          end
          ST_ERR_FLAG: begin
            bitCnt  <= cfa_inc(bitCnt);
            eqCnt   <= next_eq;
            lastLvl <= rxS;
            if (flagPassive ? (next_eq == FLAG_RUN) :
                (bitCnt == FLAG_LAST)) begin
              state    <= ST_ERR_DELIM;
              canTx    <= RECESSIVE;
              bitCnt   <= CNT_ZERO;
              delimRun <= 1'h0;
            end
          end
          ST_OVL_FLAG: begin
            bitCnt <= cfa_inc(bitCnt);
            if (bitCnt == FLAG_LAST) begin
              state    <= ST_OVL_DELIM;
              canTx    <= RECESSIVE;
              bitCnt   <= CNT_ZERO;
              delimRun <= 1'h0;
            end
          end
          ST_ERR_DELIM, ST_OVL_DELIM: begin
            canTx <= RECESSIVE;
            if (!delimRun) begin
              if (!dom) begin
                delimRun <= 1'h1;
                bitCnt   <= CNT_ONE;
              end
            end else if (bitCnt == DELIM_LAST) begin
              bitCnt <= CNT_ZERO;
              if (dom) begin
                state <= ST_OVL_FLAG;
                canTx <= DOMINANT;
              end else begin
                state <= ST_INTER;
              end
            end else if (dom) begin
              state       <= ST_ERR_FLAG;
              bitCnt      <= CNT_ZERO;
              eqCnt       <= CNT_ZERO;
              flagPassive <= errPassive;
              canTx       <= errPassive ? RECESSIVE : DOMINANT;
            end else begin
              bitCnt <= cfa_inc(bitCnt);
            end
          end
          ST_INTER: begin
            if (dom && (bitCnt <= OVLW_LAST)) begin
              state  <= ST_OVL_FLAG;
              canTx  <= DOMINANT;
              bitCnt <= CNT_ZERO;
            end else if (dom) begin
              state   <= ST_FRAME;
              sofSeen <= 1'h1;
              if (txPending) begin
                txActive <= 1'h1;
                canTx    <= txBit;
                txTake   <= 1'h1;
              end
            end else if (bitCnt == INTER_LAST) begin
              bitCnt <= CNT_ZERO;
              if (errPassive && wasTx) begin
                state <= ST_SUSPEND;
              end else if (txPending) begin
                state    <= ST_FRAME;
                canTx    <= DOMINANT;
                txActive <= 1'h1;
                sofSeen  <= 1'h1;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              bitCnt <= cfa_inc(bitCnt);
            end
          end
          ST_SUSPEND: begin
            wasTx <= 1'h0;
            if (dom) begin
              state   <= ST_FRAME;
              sofSeen <= 1'h1;
            end else if (bitCnt == SUSP_LAST) begin
              bitCnt <= CNT_ZERO;
              if (txPending) begin
                state    <= ST_FRAME;
                canTx    <= DOMINANT;
                txActive <= 1'h1;
                sofSeen  <= 1'h1;
              end else begin
                state <= ST_IDLE;
              end
            end else begin
              bitCnt <= cfa_inc(bitCnt);
            end
          end
          default: begin
            state <= ST_INTER;
            canTx <= RECESSIVE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  a_err_next_bit: assert property (
    @(posedge ref_clk) disable iff (srst)
    bitTick && (state == ST_FRAME) && errDetect
    |=> (state == ST_ERR_FLAG) &&
        (canTx == (flagPassive ? RECESSIVE : DOMINANT)))
    else $error("error flag not started on next bit");

  a_active_flag_dom: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == ST_ERR_FLAG) && !flagPassive |-> canTx == DOMINANT)
    else $error("active error flag not dominant");

  a_passive_flag_rec: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == ST_ERR_FLAG) && flagPassive |-> canTx == RECESSIVE)
    else $error("passive error flag not recessive");

  a_delim_recessive: assert property (
    @(posedge ref_clk) disable iff (srst)
    $past(state == ST_ERR_DELIM) && (state == ST_ERR_DELIM)
    |-> canTx == RECESSIVE)
    else $error("delimiter bit driven dominant");

  a_ovl_flag_dom: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == ST_OVL_FLAG) |-> canTx == DOMINANT)
    else $error("overload flag not dominant");

  a_arb_loss_stop: assert property (
    @(posedge ref_clk) disable iff (srst)
    bitTick && (state == ST_FRAME) && txActive && txArb && !stuffNow &&
    !errDetect && !eofLast && !(ackDelim && crcPend) &&
    (canTx == RECESSIVE) && dom
    |=> !txActive && arbLost && (canTx == RECESSIVE))
    else $error("arbitration loss did not stop sending");

  a_suspend_quiet: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == ST_SUSPEND) |-> (canTx == RECESSIVE) && !txActive)
    else $error("sending during suspend");

  a_crc_deferred: assert property (
    @(posedge ref_clk) disable iff (srst)
    bitTick && (state == ST_FRAME) && crcPend && ackDelim
    |=> state == ST_ERR_FLAG)
    else $error("deferred crc flag missing");

  a_inter_overload: assert property (
    @(posedge ref_clk) disable iff (srst)
    bitTick && (state == ST_INTER) && dom && (bitCnt <= OVLW_LAST)
    |=> (state == ST_OVL_FLAG) && (canTx == DOMINANT))
    else $error("no overload after dominant intermission bit");

  a_stuff_insert: assert property (
    @(posedge ref_clk) disable iff (srst)
    bitTick && (state == ST_FRAME) && txActive && stuffNext &&
    !errDetect && !eofLast && !(ackDelim && crcPend) &&
    !(txArb && !stuffNow && (canTx == RECESSIVE) && dom)
    |=> canTx == !$past(rxS))
    else $error("stuff bit not inserted");

endmodule // cfa_core
`default_nettype wire

// file: cfa_bus_node.sv
// Model of another node on the shared bus, driving a scripted level.
// Assumes bit ticks from the bench and wired-AND resolution outside.
`timescale 1ns/100ps
`default_nettype none
module cfa_bus_node
  import cfa_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        bitTick,
  input  wire logic        load,
  input  wire logic [63:0] script,
  output var  logic        nodeTx
);
  // ==========================================================
  // Script shifter, released bits fall back to recessive
  logic [63:0] shiftReg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shiftReg <= {64{RECESSIVE}};
      nodeTx   <= RECESSIVE;
    end else if (load) begin
      shiftReg <= script;
    end else if (bitTick) begin
      // One level per bit, pre-stuffed, echo flags scripted
      nodeTx   <= shiftReg[0];
      shiftReg <= {RECESSIVE, shiftReg[63:1]};
    end
  end
endmodule // cfa_bus_node
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the bit-level protocol core.
// Assumes a bit tick every 8 clocks and one scripted peer node.
`timescale 1ns/100ps
`default_nettype none
module testbench
  import cfa_pkg::*;
;
  logic        ref_clk, srst, bitTick, txPending, txArb, stuffRegion;
  logic        errDetect, crcErr, ackDelim, eofLast, errPassive;
  logic        rxReady, load, txBit;
  logic        canTx, txTake, rxValid, rxBit, rxOverrun, txActive;
  logic        arbLost, sofSeen, busIdle, nodeTx;
  wire  logic  canRx;
  logic [63:0] script;
  logic [15:0] txPat;
  logic [3:0]  txIdx;
  logic [2:0]  tickCnt;
  logic        rxQ[$];
  int          bad_count, num_checks, cycles;

  // ==========================================================
  // Wired bus, dominant wins
  assign canRx = canTx & nodeTx;
  assign txBit = txPat[txIdx];

  cfa_core dut (
    .ref_clk(ref_clk), .srst(srst), .bitTick(bitTick), .canRx(canRx),
    .canTx(canTx), .txPending(txPending), .txBit(txBit), .txArb(txArb),
    .txTake(txTake), .stuffRegion(stuffRegion), .errDetect(errDetect),
    .crcErr(crcErr), .ackDelim(ackDelim), .eofLast(eofLast),
    .errPassive(errPassive), .rxValid(rxValid), .rxBit(rxBit),
    .rxReady(rxReady), .rxOverrun(rxOverrun), .txActive(txActive),
    .arbLost(arbLost), .sofSeen(sofSeen), .busIdle(busIdle)
  );

  cfa_bus_node peer (
    .ref_clk(ref_clk), .srst(srst), .bitTick(bitTick), .load(load),
    .script(script), .nodeTx(nodeTx)
  );

  // ==========================================================
  // Clock, bit ticks, frame feeder, receive sink, timeout
  always #10 ref_clk = ~ref_clk;

  always @(negedge ref_clk) begin
    tickCnt <= tickCnt + 3'h1;
    bitTick <= (tickCnt == 3'h7);
    if (txTake === 1'h1)
      txIdx <= txIdx + 4'h1;
  end

  always @(posedge ref_clk) begin
    if (rxValid === 1'h1 && rxReady === 1'h1)
      rxQ.push_back(rxBit);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    num_checks++;
    if (seen !== expd) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic wait_tick();
    @(posedge ref_clk iff bitTick === 1'h1);
    @(negedge ref_clk);
  endtask

  task automatic reset_dut();
    @(negedge ref_clk);
    srst = 1'h1;
    txPending = 1'h0;
    errDetect = 1'h0;
    ackDelim = 1'h0;
    stuffRegion = 1'h0;
    repeat (6) @(negedge ref_clk);
    srst = 1'h0;
    txIdx = 4'h0;
    rxQ.delete();
    repeat (12) wait_tick();
  endtask

  // Peer opens a frame; SOF sampled on return
  task automatic start_frame(input logic [63:0] pat);
    reset_dut();
    script = pat;
    load = 1'h1;
    stuffRegion = 1'h1;
    @(negedge ref_clk);
    load = 1'h0;
    wait_tick();
    wait_tick();
    check(sofSeen, 1'h1);
  endtask

  // ==========================================================
  // Scenarios
  task automatic err_active(input int d, input logic crc);
    logic [63:0] pat;
    pat = {64{RECESSIVE}};
    pat[0] = DOMINANT;
    pat[2] = DOMINANT;
    if (d > 0)
      pat[d + 3] = DOMINANT;
    errPassive = 1'h0;
    start_frame(pat);
    crcErr = crc;
    wait_tick();
    crcErr = 1'h0;
    check(canTx, RECESSIVE);
    wait_tick();
    if (crc)
      ackDelim = 1'h1;
    else
      errDetect = 1'h1;
    wait_tick();
    ackDelim = 1'h0;
    errDetect = 1'h0;
    stuffRegion = 1'h0;
    for (int j = 1; j <= 6; j++) begin
      check(canTx, DOMINANT);
      wait_tick();
    end
    for (int j = 7; j <= ((d > 0) ? d : 16); j++) begin
      check(canTx, RECESSIVE);
      wait_tick();
    end
    if (d == 0) begin
      txPending = 1'h1;
      @(negedge ref_clk);
      check(busIdle, 1'h0);
      wait_tick();
      check(canTx, DOMINANT);
    end else begin
      for (int j = 1; j <= 6; j++) begin
        check(canTx, DOMINANT);
        wait_tick();
      end
      check(canTx, RECESSIVE);
    end
  endtask

  task automatic err_passive();
    logic [63:0] pat;
    pat = {64{RECESSIVE}};
    pat[0] = DOMINANT;
    pat[2] = DOMINANT;
    pat[6:4] = 3'h0;
    errPassive = 1'h1;
    start_frame(pat);
    wait_tick();
    wait_tick();
    errDetect = 1'h1;
    wait_tick();
    errDetect = 1'h0;
    for (int j = 1; j <= 17; j++) begin
      check(canTx, RECESSIVE);
      wait_tick();
    end
    @(negedge ref_clk);
    check(busIdle, 1'h0);
    repeat (6) wait_tick();
    check(busIdle, 1'h1);
  endtask

  task automatic eof_overload();
    logic [63:0] pat;
    pat = {64{RECESSIVE}};
    pat[0] = DOMINANT;
    pat[3] = DOMINANT;
    errPassive = 1'h0;
    start_frame(pat);
    stuffRegion = 1'h0;
    wait_tick();
    wait_tick();
    eofLast = 1'h1;
    wait_tick();
    eofLast = 1'h0;
    for (int j = 1; j <= 6; j++) begin
      check(canTx, DOMINANT);
      wait_tick();
    end
    check(canTx, RECESSIVE);
  endtask

  task automatic tx_arb();
    logic [7:0] expTx;
    logic [6:0] expRx;
    expTx = 8'hE0;
    expRx = 7'h40;
    reset_dut();
    errPassive = 1'h0;
    txPat = 16'hFFF0;
    script = 64'hFFFF_FFFF_FFFF_FFA0;
    load = 1'h1;
    txPending = 1'h1;
    stuffRegion = 1'h1;
    @(negedge ref_clk);
    load = 1'h0;
    for (int k = 0; k < 8; k++) begin
      wait_tick();
      check(canTx, expTx[k]);
      if (k == 0)
        check({txActive, sofSeen}, 2'h3);
    end
    check({arbLost, txActive}, 2'h2);
    check(txIdx, 4'h5);
    repeat (2) wait_tick();
    for (int k = 0; k < 7; k++)
      check(rxQ[k], expRx[k]);
  endtask

  task automatic rx_overrun();
    rxReady = 1'h0;
    start_frame(64'hFFFF_FFFF_FFFF_FFFA);
    check(rxValid, 1'h1);
    wait_tick();
    check(rxOverrun, 1'h0);
    wait_tick();
    check({rxOverrun, canTx}, 2'h3);
    rxReady = 1'h1;
    repeat (3) @(negedge ref_clk);
    check({rxValid, rxQ[0], rxQ[1]}, 3'h1);
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    ref_clk = 1'h0;
    srst = 1'h1;
    bitTick = 1'h0;
    tickCnt = 3'h0;
    txPending = 1'h0;
    txPat = 16'hFFFF;
    txIdx = 4'h0;
    txArb = 1'h1;
    stuffRegion = 1'h0;
    errDetect = 1'h0;
    crcErr = 1'h0;
    ackDelim = 1'h0;
    eofLast = 1'h0;
    errPassive = 1'h0;
    rxReady = 1'h1;
    load = 1'h0;
    script = {64{RECESSIVE}};
    bad_count = 0;
    num_checks = 0;
    cycles = 0;
    err_active(0, 1'h0);
    err_active(0, 1'h1);
    err_active(14, 1'h0);
    err_active(15, 1'h0);
    err_active(16, 1'h0);
    err_passive();
    eof_overload();
    tx_arb();
    rx_overrun();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
